// ==== pkg/cbr_pkg.sv ====
// Package for the clock buffer upper register bank: offsets, reset values,
// field positions and the carrier type for the two controlled output pairs.
// Assumes a single 25 MHz clock domain; used by design/cbr_regs.sv and by the bench.
`default_nettype none
package cbr_pkg;
    // Register indices (byte offsets on the serial bus)
    localparam logic [7:0] OFF_OUT_EN = 8'h02;
    localparam logic [7:0] OFF_RSV_A = 8'h03;
    localparam logic [7:0] OFF_RSV_B = 8'h04;
    localparam logic [7:0] OFF_MAKER_REV = 8'h05;
    localparam logic [7:0] OFF_PART = 8'h06;
    localparam logic [7:0] OFF_RB_LEN = 8'h07;
    // Field positions inside the output enable byte
    localparam int POS_PAIR7 = 2;
    localparam int POS_PAIR6 = 0;
    localparam int POS_FIXED_ONE = 3;
    // Reset values
    localparam logic RST_PAIR_EN = 1'b1;
    localparam logic [4:0] RST_RB_LEN = 5'h08;
    localparam logic [7:0] RST_INDEX = 8'h00;
    // Serial framing
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
    // One flag per controlled output pair
    typedef struct packed {
        logic pair7;
        logic pair6;
    } cbr_pair_t;
endpackage
`default_nettype wire

// ==== design/cbr_regs.sv ====
// Upper register bank of a clock fanout buffer with its serial slave port.
// Assumes bus clock and data inputs synchronous to ref_clk and an external
// open-drain wire resolved from smb_data_oe (low while it is high).
//
// What this block does
// - Byte 2 bits 2 and 0 enable pairs; 0 forces low/low, reset 1.
// - Bytes 3 and 4 are reserved and read back as zero.
// - Byte 5 is read-only: fixed revision high nibble, maker low nibble.
// - Byte 6 is a read-only fixed eight-bit part identifier.
// - Byte 7 bits 4:0 are a writable read-back length; bits 7:5 reserved.
// - Read-back length resets to 8 and is sent as the count byte; reads run until the host NACKs.
// - Byte 2 bit 3 reads 1; bits 7:4 and 1 are reserved zero.
// - Block read: index write, repeated start, count byte, data, host NACK, stop.
// - Block write: address, index, count, data bytes each acknowledged, then stop.
`timescale 1ns/1ps
`default_nettype none
module cbr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter logic [3:0] REV_CODE = 4'h1, // Arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'h5, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h3c // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic smb_clk,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe,
    input wire cbr_pkg::cbr_pair_t pair_oe_pin_n,
    output cbr_pkg::cbr_pair_t pair_enable,
    output cbr_pkg::cbr_pair_t pair_run,
    output logic [4:0] readback_length
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_INDEX, ST_WCOUNT, ST_WDATA, ST_RD_ACK, ST_TX
    } cbr_state_t;

    cbr_state_t state_q;
    logic scl_q, sda_q;
    logic [3:0] bit_q;
    logic [7:0] shreg_q, tx_q, idx_q;
    logic host_ack_q;
    cbr_pkg::cbr_pair_t en_q;
    logic [4:0] len_q;
    logic scl_rise, scl_fall, start_c, stop_c, byte_end, ack_end, addr_hit;
    logic wr_stb;
    logic [7:0] cnt_byte, next_byte;

    // Read view of the bank, reserved bits as zero
    function automatic logic [7:0] rd_byte(input logic [7:0] idx, input cbr_pkg::cbr_pair_t en,
                                           input logic [4:0] len);
        logic [7:0] b;
        b = cbr_pkg::UNMAPPED_BYTE;
        case (idx)
            cbr_pkg::OFF_OUT_EN: begin
                b[cbr_pkg::POS_FIXED_ONE] = 1'b1;
                b[cbr_pkg::POS_PAIR7] = en.pair7;
                b[cbr_pkg::POS_PAIR6] = en.pair6;
            end
            cbr_pkg::OFF_RSV_A: b = 8'h00;
            cbr_pkg::OFF_RSV_B: b = 8'h00;
            cbr_pkg::OFF_MAKER_REV: b = {REV_CODE, MAKER_CODE};
            cbr_pkg::OFF_PART: b = PART_CODE;
            cbr_pkg::OFF_RB_LEN: b = {3'h0, len};
            default: b = cbr_pkg::UNMAPPED_BYTE;
        endcase
        return b;
    endfunction

    // Bus condition decode
    assign scl_rise = smb_clk && !scl_q;
    assign scl_fall = !smb_clk && scl_q;
    assign start_c = smb_clk && scl_q && sda_q && !smb_data_in;
    assign stop_c = smb_clk && scl_q && !sda_q && smb_data_in;
    assign byte_end = scl_fall && bit_q == cbr_pkg::BIT_LAST;
    assign ack_end = scl_fall && bit_q == cbr_pkg::BIT_ACK;
    assign addr_hit = state_q == ST_ADDR && shreg_q[7:1] == DEV_ADDR;
    assign wr_stb = byte_end && state_q == ST_WDATA;
    // Bytes waiting to be sent: the count leads, then the bank from the index
    assign cnt_byte = {3'h0, len_q};
    assign next_byte = rd_byte(idx_q, en_q, len_q);

    // Previous pin levels for edge and condition detection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= smb_clk;
            sda_q <= smb_data_in;
        end
    end

    // Bit counter and receive shifter
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bit_q <= 4'h0;
            shreg_q <= 8'h00;
            host_ack_q <= 1'b0;
        end else if (start_c) begin
            bit_q <= 4'hf; // Pre-wound: the fall right after a start carries no bit
        end else if (scl_rise) begin
            if (bit_q != cbr_pkg::BIT_ACK) begin
                shreg_q <= {shreg_q[6:0], smb_data_in};
            end else begin
                host_ack_q <= !smb_data_in;
            end
        end else if (scl_fall) begin
            bit_q <= (bit_q == cbr_pkg::BIT_ACK) ? 4'h0 : bit_q + 4'h1;
        end
    end

    // Transaction sequencer, index pointer and data line drive
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            idx_q <= cbr_pkg::RST_INDEX;
            tx_q <= 8'h00;
            smb_data_oe <= 1'b0;
            smb_data_out <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
            smb_data_oe <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_ADDR; // Index survives a repeated start
            smb_data_oe <= 1'b0;
        end else if (byte_end) begin
            case (state_q)
                ST_ADDR: begin
                    smb_data_oe <= addr_hit;
                    if (!addr_hit) begin
                        state_q <= ST_IDLE;
                    end else if (shreg_q[0]) begin
                        state_q <= ST_RD_ACK;
                    end else begin
                        state_q <= ST_INDEX;
                    end
                end
                ST_INDEX: begin
                    idx_q <= shreg_q;
                    smb_data_oe <= 1'b1;
                    state_q <= ST_WCOUNT;
                end
                ST_WCOUNT: begin
                    smb_data_oe <= 1'b1;
                    state_q <= ST_WDATA;
                end
                ST_WDATA: begin
                    smb_data_oe <= 1'b1;
                    idx_q <= idx_q + 8'h01;
                end
                ST_TX: smb_data_oe <= 1'b0; // Release for host acknowledge
                default: smb_data_oe <= 1'b0;
            endcase
        end else if (ack_end) begin
            case (state_q)
                ST_RD_ACK: begin
                    // Count byte leads the read data
                    tx_q <= cnt_byte << 1;
                    smb_data_oe <= !cnt_byte[7];
                    state_q <= ST_TX;
                end
                ST_TX: begin
                    if (host_ack_q) begin
                        tx_q <= next_byte << 1;
                        smb_data_oe <= !next_byte[7];
                        idx_q <= idx_q + 8'h01;
                    end else begin
                        state_q <= ST_IDLE;
                        smb_data_oe <= 1'b0;
                    end
                end
                default: smb_data_oe <= 1'b0;
            endcase
        end else if (scl_fall && state_q == ST_TX && bit_q < cbr_pkg::BIT_LAST) begin
            smb_data_oe <= !tx_q[7];
            tx_q <= tx_q << 1;
        end
    end

    // Writable fields; all other bits ignore writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            en_q <= '{pair7: cbr_pkg::RST_PAIR_EN, pair6: cbr_pkg::RST_PAIR_EN};
            len_q <= cbr_pkg::RST_RB_LEN;
        end else if (wr_stb) begin
            if (idx_q == cbr_pkg::OFF_OUT_EN) begin
                en_q.pair7 <= shreg_q[cbr_pkg::POS_PAIR7];
                en_q.pair6 <= shreg_q[cbr_pkg::POS_PAIR6];
            end
            if (idx_q == cbr_pkg::OFF_RB_LEN) begin
                len_q <= shreg_q[4:0];
            end
        end
    end

    // Output pair gating: enable bit low forces low/low over the pin
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pair_run <= '0;
        end else begin
            pair_run.pair7 <= en_q.pair7 && !pair_oe_pin_n.pair7;
            pair_run.pair6 <= en_q.pair6 && !pair_oe_pin_n.pair6;
        end
    end

    assign pair_enable = en_q;
    assign readback_length = len_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_PAIR_FORCED: assert property (!en_q.pair7 |=> !pair_run.pair7)
        else $error("Disabled pair7 is not held low");
    AST_PAIR_PIN: assert property (en_q.pair6 && !pair_oe_pin_n.pair6 ##1 en_q.pair6 |-> pair_run.pair6)
        else $error("Enabled pair6 does not follow its pin");
    // Transmitted bytes: the shifter holds bits 6:0 and the line drive shows bit 7
    AST_RSVD_ZERO: assert property (ack_end && state_q == ST_TX && host_ack_q
        && (idx_q == cbr_pkg::OFF_RSV_A || idx_q == cbr_pkg::OFF_RSV_B) |=> smb_data_oe && tx_q == 8'h00)
        else $error("Reserved byte reads nonzero");
    AST_MAKER_REV: assert property (ack_end && state_q == ST_TX && host_ack_q && idx_q == cbr_pkg::OFF_MAKER_REV
        |=> smb_data_oe == !REV_CODE[3] && tx_q == {REV_CODE[2:0], MAKER_CODE, 1'b0})
        else $error("Revision or maker field changed");
    AST_PART: assert property (ack_end && state_q == ST_TX && host_ack_q && idx_q == cbr_pkg::OFF_PART
        |=> smb_data_oe == !PART_CODE[7] && tx_q == {PART_CODE[6:0], 1'b0})
        else $error("Part code wrong");
    AST_LEN_WRITE: assert property (wr_stb && idx_q == cbr_pkg::OFF_RB_LEN |=> len_q == $past(shreg_q[4:0]))
        else $error("Length write not taken");
    AST_OUT_EN_FIXED: assert property (ack_end && state_q == ST_TX && host_ack_q && idx_q == cbr_pkg::OFF_OUT_EN
        |=> smb_data_oe && tx_q[7:4] == 4'h1 && !tx_q[2])
        else $error("Output enable reserved bits wrong");
    AST_COUNT_BYTE: assert property (ack_end && state_q == ST_RD_ACK
        |=> smb_data_oe && tx_q == {2'h0, len_q, 1'b0})
        else $error("Count byte does not carry the read-back length");
    AST_ADDR_ACK: assert property (byte_end && addr_hit && !stop_c && !start_c |=> smb_data_oe)
        else $error("Own address not acknowledged");
    AST_DATA_ACK: assert property (byte_end && state_q == ST_WDATA && !stop_c && !start_c
        |=> smb_data_oe && idx_q == $past(idx_q) + 8'h01)
        else $error("Data byte not acknowledged or index not advanced");
    AST_RO_HOLD: assert property (wr_stb && idx_q != cbr_pkg::OFF_OUT_EN |=> $stable(en_q))
        else $error("Write outside enable byte changed enables");
endmodule // cbr_regs
`default_nettype wire

// ==== verif/cbr_host.sv ====
// Host model for the serial port: makes the bus clock, releases or pulls data.
// Assumes a pull-up on the data wire, resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module cbr_host (
    input wire logic ref_clk,
    input wire logic smb_data,
    output logic smb_clk,
    output logic host_data
);
    int hold = 4;
    // Idle bus: clock and data released high
    initial begin
        smb_clk = 1'b1;
        host_data = 1'b1;
    end
    // One bus phase, set after a falling edge and held
    task automatic ph(input logic c, input logic d);
        @(negedge ref_clk);
        smb_clk = c;
        host_data = d;
        repeat (hold) @(negedge ref_clk);
    endtask
    // Start or repeated start, stop, and one clocked bit
    task automatic start();
        ph(1'b0, host_data);
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    task automatic stop();
        ph(1'b0, host_data);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    task automatic bitx(input logic b, output logic r);
        ph(1'b0, host_data);
        ph(1'b0, b);
        ph(1'b1, b);
        r = smb_data;
    endtask
    // Byte out with the device's acknowledge, byte in with host ack or nack
    task automatic wb(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic rb(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            v[i] = r;
        end
        bitx(last, r);
    endtask
endmodule // cbr_host
`default_nettype wire

// ==== verif/tb.sv ====
// Bench for the upper register bank: host model on the serial port,
// output-enable pins driven here; data wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [6:0] ADDR = 7'h2a;
    localparam logic [3:0] REV = 4'h2; // Arbitrary value
    localparam logic [3:0] MAKER = 4'h6; // Arbitrary value
    localparam logic [7:0] PART = 8'h5a; // Arbitrary value
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic smb_clk, host_data, smb_data, smb_data_out, smb_data_oe, ack;
    cbr_pkg::cbr_pair_t pins_n, pair_enable, pair_run;
    logic [4:0] readback_length;
    logic [7:0] cnt;
    logic [7:0] got [0:7];
    int bad_count = 0;
    int compares = 0;
    // Clock and resolved open-drain data wire
    always #20 ref_clk = ~ref_clk;
    assign smb_data = host_data & ~(smb_data_oe & ~smb_data_out);
    cbr_host u_host (.ref_clk(ref_clk), .smb_data(smb_data), .smb_clk(smb_clk), .host_data(host_data));
    cbr_regs #(.DEV_ADDR(ADDR), .REV_CODE(REV), .MAKER_CODE(MAKER), .PART_CODE(PART)) u_dut (
        .ref_clk(ref_clk), .reset(reset), .smb_clk(smb_clk), .smb_data_in(smb_data),
        .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .pair_oe_pin_n(pins_n),
        .pair_enable(pair_enable), .pair_run(pair_run), .readback_length(readback_length));
    // Comparison, verdict and bus transfers
    task automatic chk(input logic ok, input string m);
        compares++;
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input int n, input logic [7:0] v);
        u_host.start();
        u_host.wb({ADDR, 1'b0}, ack);
        u_host.wb(idx, ack);
        u_host.wb(8'(n), ack);
        for (int i = 0; i < n; i++) begin
            u_host.wb(v, ack);
            chk(ack === 1'b1, "data not acked");
        end
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] idx, input int n);
        u_host.start();
        u_host.wb({ADDR, 1'b0}, ack);
        u_host.wb(idx, ack);
        u_host.start();
        u_host.wb({ADDR, 1'b1}, ack);
        chk(ack === 1'b1, "read address not acked");
        u_host.rb(1'b0, cnt);
        for (int i = 0; i < n; i++) begin
            u_host.rb(i == n - 1, got[i]);
        end
        u_host.stop();
    endtask
    // Reset values of the whole bank
    task automatic t_reset();
        chk(pair_enable === 2'b11 && pair_run === 2'b11, "pair reset");
        chk(readback_length === 5'h08, "length reset");
        rd(8'h02, 7);
        chk(cnt === 8'h08 && got[5] === 8'h08, "count byte");
        chk(got[6] === 8'h00, "unmapped byte");
        chk(got[0] === 8'h0d, "enable byte");
        chk(got[1] === 8'h00 && got[2] === 8'h00, "reserved bytes");
        chk(got[3] === {REV, MAKER} && got[4] === PART, "id bytes");
    endtask
    // Enable bits override the pins; reserved bit stays
    task automatic t_pairs();
        wr(8'h02, 1, 8'h00);
        chk(pair_enable === 2'b00 && pair_run === 2'b00, "forced off");
        rd(8'h02, 1);
        chk(got[0] === 8'h08, "enable byte cleared");
        wr(8'h02, 1, 8'hff);
        pins_n = 2'b10;
        repeat (3) @(negedge ref_clk);
        chk(pair_run === 2'b01, "pin control");
        pins_n = 2'b00;
        rd(8'h02, 1);
        chk(got[0] === 8'h0d, "enable byte set");
    endtask
    // Block write over reserved and read-only bytes
    task automatic t_readonly();
        wr(8'h03, 4, 8'hff);
        rd(8'h03, 4);
        chk(got[0] === 8'h00 && got[1] === 8'h00, "reserved written");
        chk(got[2] === {REV, MAKER} && got[3] === PART, "ids written");
    endtask
    // Length field bounds, slow host, wrong address, mid-run reset
    task automatic t_count();
        wr(8'h07, 1, 8'hff);
        rd(8'h07, 1);
        chk(readback_length === 5'h1f && got[0] === 8'h1f && cnt === 8'h1f, "length max");
        wr(8'h07, 1, 8'h00);
        u_host.hold = 9;
        rd(8'h02, 2);
        u_host.hold = 4;
        chk(cnt === 8'h00 && got[1] === 8'h00, "length zero slow");
        u_host.start();
        u_host.wb({7'h2b, 1'b0}, ack);
        chk(ack === 1'b0, "foreign address acked");
        u_host.stop();
        wr(8'h02, 1, 8'h00);
        reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        chk(readback_length === 5'h08 && pair_enable === 2'b11, "second reset");
    endtask
    // Main sequence
    initial begin
        pins_n = 2'b00;
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_reset();
        t_pairs();
        t_readonly();
        t_count();
        give_verdict();
    end
    // Watchdog against a hung bus
    initial begin
        #2400000;
        bad_count++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
